//--- design/twx_regs.svh
// register map, opcodes, phases and field constants of the instruction unit
`ifndef TWX_REGS_SVH
`define TWX_REGS_SVH

// ****************************************
// widths
// ****************************************
`define TWX_PTR_W      21
`define TWX_ADDR_W     12
`define TWX_HOLD_N     8

// ****************************************
// register word indices (byte address = 4 * index)
// ****************************************
`define TWX_REG_PTR    4'h0
`define TWX_REG_LATCH  4'h1
`define TWX_REG_ACC    4'h2
`define TWX_REG_STAT   4'h3
`define TWX_REG_BANK   4'h4
`define TWX_REG_CTRL   4'h5
`define TWX_REG_IDX    4'h6
`define TWX_REG_CORE   4'h7
`define TWX_HOLD_BIT   3

// ****************************************
// field positions and reset values
// ****************************************
`define TWX_ST_Z       0
`define TWX_ST_N       1
`define TWX_CTRL_EXT   0
`define TWX_EXT_RST    1'b0
`define TWX_HOLD_RST   8'hff

// ****************************************
// opcodes
// ****************************************
`define TWX_OP_TABLE_WRITE 14'h0003
`define TWX_OP_TST     7'h33
`define TWX_OP_XORL    8'h0a
`define TWX_OP_XORF    6'h06
`define TWX_BIT_D      9
`define TWX_BIT_A      8

// ****************************************
// table write pointer modes
// ****************************************
`define TWX_MODE_KEEP  2'h0
`define TWX_MODE_POSTI 2'h1
`define TWX_MODE_POSTD 2'h2
`define TWX_MODE_PREI  2'h3

// ****************************************
// instruction cycle phases
// ****************************************
`define TWX_Q1         2'h0
`define TWX_Q2         2'h1
`define TWX_Q3         2'h2
`define TWX_Q4         2'h3

// ****************************************
// data memory addressing
// ****************************************
`define TWX_IDX_MAX    8'h5f
`define TWX_ACC_LO     4'h0
`define TWX_ACC_HI     4'hf

`endif

//--- design/twx_pkg.sv
// types shared by the instruction unit
package twx_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_EXEC,
      ST_TBL2,
      ST_SKIP1,
      ST_SKIP2
   } twx_state_t;
endpackage

//--- design/twx_core_if.sv
// bundle between the core, its phase counter and its address resolver
interface twx_core_if;
   logic [1:0]  phase;
   logic [7:0]  f;
   logic        acc_bit;
   logic [3:0]  bank;
   logic        ext_en;
   logic [11:0] idx_base;
   logic [11:0] addr;
   modport phase_src (output phase);
   modport addr_res  (input f, acc_bit, bank, ext_en, idx_base, output addr);
   modport core      (input phase, addr, output f, acc_bit, bank, ext_en, idx_base);
endinterface

//--- design/twx_qphase.sv
// four-phase instruction cycle counter
module twx_qphase
   import twx_pkg::*;
(
   input wire logic    clk,
   input wire logic    rst,
   twx_core_if.phase_src p
);
`include "twx_regs.svh"

   logic [1:0] phase_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_q <= `TWX_Q1;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   assign p.phase = phase_q;

endmodule // twx_qphase

//--- design/twx_addr_res.sv
// file operand to data memory address
module twx_addr_res
   import twx_pkg::*;
(
   twx_core_if.addr_res a
);
`include "twx_regs.svh"

   always_comb begin
      if (a.acc_bit) begin
         a.addr = {a.bank, a.f};
      end else if (a.ext_en && (a.f <= `TWX_IDX_MAX)) begin
         a.addr = a.idx_base + {4'h0, a.f};
      end else if (a.f <= `TWX_IDX_MAX) begin
         a.addr = {`TWX_ACC_LO, a.f};
      end else begin
         a.addr = {`TWX_ACC_HI, a.f};
      end
   end

endmodule // twx_addr_res

//--- design/twx_core.sv
// table write, test-and-skip and exclusive-or execution unit
module twx_core
   import twx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output      logic [31:0] avs_readdata,
   output      logic        avs_waitrequest,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   output      logic        instr_ready,
   input  wire logic        next_two_word,
   output      logic        discard_next,
   output      logic        skip_nop,
   output      logic [11:0] dmem_addr,
   output      logic        dmem_rd,
   input  wire logic [7:0]  dmem_rdata,
   output      logic        dmem_wr,
   output      logic [7:0]  dmem_wdata
);
`include "twx_regs.svh"

   // ****************************************
   // sub-blocks
   // ****************************************
   twx_core_if cif ();

   twx_qphase u_phase (
      .clk (clk),
      .rst (rst),
      .p   (cif.phase_src)
   );

   twx_addr_res u_addr (
      .a (cif.addr_res)
   );

   // ****************************************
   // state
   // ****************************************
   twx_state_t             state_q;
   logic [15:0]            ir_q;
   logic [`TWX_PTR_W-1:0]  ptr_q;
   logic [7:0]             latch_q;
   logic [7:0]             latch_tmp_q;
   logic [7:0]             acc_q;
   logic                   flag_n_q;
   logic                   flag_z_q;
   logic [3:0]             bank_q;
   logic                   ext_en_q;
   logic [11:0]            idx_base_q;
   logic [7:0]             hold_q [`TWX_HOLD_N];
   logic [7:0]             result_q;
   logic                   opnd_zero_q;
   logic                   two_word_q;
   logic                   discard_q;
   logic [11:0]            dmem_addr_q;
   logic                   ack_q;
   logic [31:0]            rdata_q;
   logic [31:0]            rd_mux;
   logic [1:0]             ph;
   logic                   is_tbl;
   logic                   is_tst;
   logic                   is_xorl;
   logic                   is_xorf;
   logic                   take;
   logic                   bus_wr;
   logic                   exec_q4;
   logic                   tbl_q4;
   logic [1:0]             tbl_mode;

   // phase counter runs free from reset; words are only taken in q1
   assign ph = cif.phase;

   // ****************************************
   // decode of the held instruction
   // ****************************************
   // words matching none of the four opcodes run as a one-cycle no-op
   assign is_tbl  = (ir_q[15:2] == `TWX_OP_TABLE_WRITE);
   assign is_tst  = (ir_q[15:9] == `TWX_OP_TST);
   assign is_xorl = (ir_q[15:8] == `TWX_OP_XORL);
   assign is_xorf = (ir_q[15:10] == `TWX_OP_XORF);

   assign take    = (state_q == ST_IDLE) && (ph == `TWX_Q1) && instr_valid;
   assign exec_q4 = (state_q == ST_EXEC) && (ph == `TWX_Q4);
   assign tbl_q4  = (state_q == ST_TBL2) && (ph == `TWX_Q4);
   assign tbl_mode = ir_q[1:0];

   // operand address is resolved from the incoming word at decode
   assign cif.f        = instr_word[7:0];
   assign cif.acc_bit  = instr_word[`TWX_BIT_A];
   assign cif.bank     = bank_q;
   assign cif.ext_en   = ext_en_q;
   assign cif.idx_base = idx_base_q;

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         ir_q    <= 16'h0000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (take) begin
                  ir_q    <= instr_word;
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (ph == `TWX_Q4) begin
                  if (is_tbl) begin
                     state_q <= ST_TBL2;
                  end else if (is_tst && opnd_zero_q) begin
                     state_q <= ST_SKIP1;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_TBL2: begin
               if (ph == `TWX_Q4) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_SKIP1: begin
               if (ph == `TWX_Q4) begin
                  state_q <= two_word_q ? ST_SKIP2 : ST_IDLE;
               end
            end
            ST_SKIP2: begin
               if (ph == `TWX_Q4) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // two-word status of the fetched word is known by the skip decision
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         two_word_q <= 1'b0;
         discard_q  <= 1'b0;
      end else begin
         if (exec_q4) begin
            two_word_q <= next_two_word;
         end
         discard_q <= exec_q4 && is_tst && opnd_zero_q;
      end
   end

   // ****************************************
   // operand fetch and alu
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dmem_addr_q <= 12'h000;
         result_q    <= 8'h00;
         opnd_zero_q <= 1'b0;
      end else begin
         if (take) begin
            dmem_addr_q <= cif.addr;
         end
         if ((state_q == ST_EXEC) && (ph == `TWX_Q3)) begin
            if (is_xorl) begin
               result_q <= acc_q ^ ir_q[7:0];
            end else begin
               result_q <= acc_q ^ dmem_rdata;
            end
            opnd_zero_q <= (dmem_rdata == 8'h00);
         end
      end
   end

   // accumulator and flags; the core wins over a same-edge bus write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q    <= 8'h00;
         flag_n_q <= 1'b0;
         flag_z_q <= 1'b0;
      end else if (exec_q4 && (is_xorl || is_xorf)) begin
         if (is_xorl || !ir_q[`TWX_BIT_D]) begin
            acc_q <= result_q;
         end
         flag_n_q <= result_q[7];
         flag_z_q <= (result_q == 8'h00);
      end else if (bus_wr && (avs_address == `TWX_REG_ACC)) begin
         acc_q <= avs_writedata[7:0];
      end else if (bus_wr && (avs_address == `TWX_REG_STAT)) begin
         flag_n_q <= avs_writedata[`TWX_ST_N];
         flag_z_q <= avs_writedata[`TWX_ST_Z];
      end
   end

   // ****************************************
   // table write
   // ****************************************
   // pre-increment lands at q2 so the q4 write already sees the new pointer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_q <= '0;
      end else if ((state_q == ST_TBL2) && (ph == `TWX_Q2)
                   && (tbl_mode == `TWX_MODE_PREI)) begin
         ptr_q <= ptr_q + `TWX_PTR_W'(1);
      end else if (tbl_q4 && (tbl_mode == `TWX_MODE_POSTI)) begin
         ptr_q <= ptr_q + `TWX_PTR_W'(1);
      end else if (tbl_q4 && (tbl_mode == `TWX_MODE_POSTD)) begin
         ptr_q <= ptr_q - `TWX_PTR_W'(1);
      end else if (bus_wr && (avs_address == `TWX_REG_PTR)) begin
         ptr_q <= avs_writedata[`TWX_PTR_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_tmp_q <= 8'h00;
      end else if ((state_q == ST_TBL2) && (ph == `TWX_Q3)) begin
         latch_tmp_q <= latch_q;
      end
   end

   // bit 0 of the index is the byte-in-word select, so even/odd holding
   // slots are the low/high bytes of program words
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `TWX_HOLD_N; i++) begin
            hold_q[i] <= `TWX_HOLD_RST;
         end
      end else if (tbl_q4) begin
         hold_q[ptr_q[2:0]] <= latch_tmp_q;
      end
   end

   // ****************************************
   // software configuration
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_q    <= 8'h00;
         bank_q     <= 4'h0;
         ext_en_q   <= `TWX_EXT_RST;
         idx_base_q <= 12'h000;
      end else if (bus_wr) begin
         if (avs_address == `TWX_REG_LATCH) begin
            latch_q <= avs_writedata[7:0];
         end else if (avs_address == `TWX_REG_BANK) begin
            bank_q <= avs_writedata[3:0];
         end else if (avs_address == `TWX_REG_CTRL) begin
            ext_en_q <= avs_writedata[`TWX_CTRL_EXT];
         end else if (avs_address == `TWX_REG_IDX) begin
            idx_base_q <= avs_writedata[11:0];
         end
      end
   end

   // ****************************************
   // avalon slave
   // ****************************************
   // fixed one wait state: readdata is registered during it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   assign bus_wr = avs_write && ack_q;

   // index 7 and the holding slots have no write path, so writes there drop
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (avs_address[`TWX_HOLD_BIT]) begin
         rd_mux[7:0] = hold_q[avs_address[2:0]];
      end else if (avs_address == `TWX_REG_PTR) begin
         rd_mux[`TWX_PTR_W-1:0] = ptr_q;
      end else if (avs_address == `TWX_REG_LATCH) begin
         rd_mux[7:0] = latch_q;
      end else if (avs_address == `TWX_REG_ACC) begin
         rd_mux[7:0] = acc_q;
      end else if (avs_address == `TWX_REG_STAT) begin
         rd_mux[`TWX_ST_N] = flag_n_q;
         rd_mux[`TWX_ST_Z] = flag_z_q;
      end else if (avs_address == `TWX_REG_BANK) begin
         rd_mux[3:0] = bank_q;
      end else if (avs_address == `TWX_REG_CTRL) begin
         rd_mux[`TWX_CTRL_EXT] = ext_en_q;
      end else if (avs_address == `TWX_REG_IDX) begin
         rd_mux[11:0] = idx_base_q;
      end else begin
         rd_mux[2:0] = state_q;
         rd_mux[5:4] = ph;
      end
   end

   // captured in the wait cycle only, so readdata holds while the master samples it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         rdata_q <= rd_mux;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign instr_ready     = (state_q == ST_IDLE) && (ph == `TWX_Q1);
   assign discard_next    = discard_q;
   // decoded from state so it spans all four phases of each skip cycle
   assign skip_nop        = (state_q == ST_SKIP1) || (state_q == ST_SKIP2);
   assign dmem_addr       = dmem_addr_q;
   assign dmem_rd         = (state_q == ST_EXEC) && (ph == `TWX_Q2) && (is_tst || is_xorf);
   assign dmem_wr         = exec_q4 && is_xorf && ir_q[`TWX_BIT_D];
   assign dmem_wdata      = result_q;

endmodule // twx_core

//--- dv/twx_dmem_model.sv
// data memory model standing behind the execution unit
module twx_dmem_model (
   input  wire logic        clk,
   input  wire logic [11:0] dmem_addr,
   input  wire logic        dmem_rd,
   input  wire logic        dmem_wr,
   input  wire logic [7:0]  dmem_wdata,
   output      logic [7:0]  dmem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [4096];
   initial dmem_rdata = 8'h5a;
   // ********
   // read data stand one cycle only; scrambled otherwise so stale use shows
   // ********
   always @(posedge clk) begin
      if (dmem_rd)
         dmem_rdata <= mem[dmem_addr];
      else
         dmem_rdata <= ~dmem_rdata;
      if (dmem_wr)
         mem[dmem_addr] <= dmem_wdata;
   end
endmodule // twx_dmem_model

//--- dv/twx_core_assertions.sv
// port checks of the execution unit
`include "twx_regs.svh"
module twx_core_checker import twx_pkg::*; (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic        instr_ready,
   input wire logic        next_two_word,
   input wire logic        discard_next,
   input wire logic        skip_nop,
   input wire logic [11:0] dmem_addr,
   input wire logic        dmem_rd,
   input wire logic [7:0]  dmem_rdata,
   input wire logic        dmem_wr,
   input wire logic [7:0]  dmem_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // decoded takes
   // ********
   wire       take = instr_valid && instr_ready;
   wire       tst  = take && instr_word[15:9] == `TWX_OP_TST;
   wire       xf   = take && instr_word[15:10] == `TWX_OP_XORF;
   wire       xl   = take && instr_word[15:8] == `TWX_OP_XORL;
   wire       tw   = take && instr_word[15:2] == `TWX_OP_TABLE_WRITE;
   wire [7:0] fa   = instr_word[7:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence zero_s;
      tst ##2 dmem_rdata == 8'h00;
   endsequence
   sequence nonzero_s;
      tst ##2 dmem_rdata != 8'h00;
   endsequence
   wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus wait longer than one cycle");
   tst_read_a: assert property (tst |=> dmem_rd ##1 !dmem_rd)
      else $error("test read strobe misplaced");
   skip_one_a: assert property (zero_s ##1 !next_two_word |=> skip_nop [*4] ##1 !skip_nop)
      else $error("one word skip length wrong");
   skip_two_a: assert property (zero_s ##1 next_two_word |=> skip_nop [*8] ##1 !skip_nop)
      else $error("two word skip length wrong");
   no_skip_a: assert property (nonzero_s |=> !skip_nop [*5])
      else $error("skip on nonzero operand");
   drop_next_a: assert property (zero_s |-> ##2 discard_next ##1 !discard_next)
      else $error("discard pulse wrong");
   xf_write_a: assert property (xf && instr_word[9] |=> dmem_rd ##2 dmem_wr ##1 !dmem_wr)
      else $error("file xor write missing");
   xf_keep_a: assert property (xf && !instr_word[9] |-> ##3 !dmem_wr)
      else $error("file xor wrote file");
   xl_nomem_a: assert property (xl |=> !dmem_rd [*3])
      else $error("literal xor read memory");
   acc_bank_a: assert property (xf && !instr_word[8] && fa >= 8'h60 |=> dmem_addr == {4'hf, $past(fa)})
      else $error("upper access bank address wrong");
   tw_busy_a: assert property (tw |=> !instr_ready [*7] ##1 instr_ready)
      else $error("table write length wrong");
endmodule // twx_core_checker
bind twx_core twx_core_checker u_chk (
   .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
   .avs_waitrequest, .instr_valid, .instr_word, .instr_ready, .next_two_word,
   .discard_next, .skip_nop, .dmem_addr, .dmem_rd, .dmem_rdata, .dmem_wr, .dmem_wdata
);

//--- dv/tb_table_write_skip_xor_exec.sv
// self-checking bench of the table write, skip and xor unit
`include "twx_regs.svh"
module tb_table_write_skip_xor_exec import twx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, avs_read, avs_write, avs_waitrequest, instr_valid, instr_ready;
   logic        next_two_word, discard_next, skip_nop, dmem_rd, dmem_wr, a, d, x;
   logic [3:0]  avs_address, bank;
   logic [31:0] avs_writedata, avs_readdata, rd, s;
   logic [15:0] instr_word;
   logic [11:0] dmem_addr, ad, ib, e;
   logic [7:0]  dmem_rdata, dmem_wdata, acc, k, f, v, r, lat;
   logic [7:0]  hold_m [8];
   logic [20:0] p;
   int          err_count, checked, nops, discs, i, j;
   twx_core uut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .instr_valid, .instr_word, .instr_ready,
      .next_two_word, .discard_next, .skip_nop, .dmem_addr, .dmem_rd, .dmem_rdata,
      .dmem_wr, .dmem_wdata);
   twx_dmem_model u_mem (.clk, .dmem_addr, .dmem_rd, .dmem_wr, .dmem_wdata, .dmem_rdata);
   always #5 clk = ~clk;
   always @(negedge clk) begin
      if (skip_nop === 1'b1) nops++;
      if (discard_next === 1'b1) discs++;
   end
   // ********
   // helpers
   // ********
   function automatic logic [11:0] ea(input logic [7:0] fa, input logic aa);
      if (aa) return {bank, fa};
      if (x && fa <= `TWX_IDX_MAX) return ib + {4'h0, fa};
      return {(fa <= `TWX_IDX_MAX) ? 4'h0 : 4'hf, fa};
   endfunction
   function automatic logic [31:0] nz(input logic [7:0] y);
      return {30'h0, y[7], y == 8'h00};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (err_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // request held until the edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [3:0] ai, input logic [31:0] wd);
      int n;
      @(posedge clk);
      avs_read      <= !wr;
      avs_write     <= wr;
      avs_address   <= ai;
      avs_writedata <= wd;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) err_count++;
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic exec(input logic [15:0] w);
      int n;
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word  <= w;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (instr_ready !== 1'b1 && n < 40);
      @(posedge clk);
      instr_valid <= 1'b0;
      nops = 0;
      discs = 0;
      @(negedge clk);
      ad = dmem_addr;
      do begin
         @(negedge clk);
         n++;
      end while (instr_ready !== 1'b1 && n < 80);
      if (n >= 80) err_count++;
      @(posedge clk);
   endtask
   initial begin
      #100us;
      err_count++;
      close_out();
   end
   initial begin
      {clk, avs_read, avs_write, instr_valid, next_two_word} = 5'h0;
      {avs_address, avs_writedata, instr_word} = 52'h0;
      rst = 1'b1;
      err_count = 0;
      checked = 0;
      void'($urandom(32'hf672));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      bus(0, `TWX_REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      for (i = 0; i < 8; i++) begin
         hold_m[i] = `TWX_HOLD_RST;
         bus(0, 4'h8 + i[3:0], 32'h0);
         chk(rd, {24'h0, hold_m[i]});
      end
      for (i = 0; i < 6; i++) begin
         acc = 8'($urandom);
         k = (i == 0) ? acc : 8'($urandom);
         bus(1, `TWX_REG_ACC, {24'h0, acc});
         exec({`TWX_OP_XORL, k});
         bus(0, `TWX_REG_ACC, 32'h0);
         chk(rd, {24'h0, acc ^ k});
         bus(0, `TWX_REG_STAT, 32'h0);
         chk(rd, nz(acc ^ k));
      end
      // low indices pin the access bank boundary with both extended settings
      for (i = 0; i < 10; i++) begin
         {a, d, x} = 3'($urandom);
         f = 8'($urandom);
         if (i < 4) begin
            a = 1'b0;
            x = i[0] ^ i[1];
            f = i[0] ? 8'h60 : `TWX_IDX_MAX;
         end
         {bank, ib, acc, v} = 32'($urandom);
         bus(1, `TWX_REG_BANK, {28'h0, bank});
         bus(1, `TWX_REG_CTRL, {31'h0, x});
         bus(1, `TWX_REG_IDX, {20'h0, ib});
         bus(1, `TWX_REG_ACC, {24'h0, acc});
         e = ea(f, a);
         u_mem.mem[e] = v;
         r = acc ^ v;
         exec({`TWX_OP_XORF, d, a, f});
         chk(ad, e);
         if (d) chk(u_mem.mem[e], r);
         bus(0, `TWX_REG_ACC, 32'h0);
         chk(rd, {24'h0, d ? acc : r});
         bus(0, `TWX_REG_STAT, 32'h0);
         chk(rd, nz(r));
      end
      for (i = 0; i < 8; i++) begin
         s = {30'h0, 2'($urandom)};
         a = i[2];
         f = 8'($urandom);
         e = ea(f, a);
         u_mem.mem[e] = i[0] ? 8'h00 : (8'($urandom) | 8'h01);
         bus(1, `TWX_REG_STAT, s);
         next_two_word <= i[1];
         exec({`TWX_OP_TST, a, f});
         chk(nops, i[0] ? (i[1] ? 8 : 4) : 0);
         chk(discs, i[0]);
         bus(0, `TWX_REG_STAT, 32'h0);
         chk(rd, s);
      end
      // iterations 2 and 3 wrap the pointer downward and upward
      for (i = 0; i < 8; i++) begin
         p = (i == 2) ? 21'h0 : (i == 3) ? 21'h1fffff : 21'($urandom);
         lat = 8'($urandom);
         bus(1, `TWX_REG_PTR, {11'h7ff, p});
         bus(1, `TWX_REG_LATCH, {24'h0, lat});
         exec({`TWX_OP_TABLE_WRITE, i[1:0]});
         if (i[1:0] == `TWX_MODE_PREI) p = p + 21'h1;
         hold_m[p[2:0]] = lat;
         if (i[1:0] == `TWX_MODE_POSTI) p = p + 21'h1;
         if (i[1:0] == `TWX_MODE_POSTD) p = p - 21'h1;
         bus(0, `TWX_REG_PTR, 32'h0);
         chk(rd, {11'h0, p});
         bus(0, `TWX_REG_STAT, 32'h0);
         chk(rd, s);
         for (j = 0; j < 8; j++) begin
            bus(0, 4'h8 + j[3:0], 32'h0);
            chk(rd, {24'h0, hold_m[j]});
         end
      end
      bus(1, 4'h9, {24'h0, ~hold_m[1]});
      bus(0, 4'h9, 32'h0);
      chk(rd, {24'h0, hold_m[1]});
      close_out();
   end
endmodule // tb_table_write_skip_xor_exec
